/* include/adc_ctrl_pkg.sv */
// package for the converter result and trigger control block
// assumes a 100 MHz system clock and an APB slave with byte-wide registers
package adc_ctrl_pkg;
	// register indexes; printed offsets are not all multiples of four
	localparam logic [7:0] idx_analog_misc     = 8'h77;
	localparam logic [7:0] idx_result_low      = 8'h78;
	localparam logic [7:0] idx_result_high     = 8'h79;
	localparam logic [7:0] idx_control_b       = 8'h7B;
	localparam logic [7:0] idx_input_off_low   = 8'h7E;
	localparam logic [7:0] idx_input_off_high  = 8'h7F;
	localparam logic [7:0] idx_converter_ctrl  = 8'h7A;
	// byte addresses on the bus are four times the index
	localparam logic [9:0] addr_analog_misc    = {idx_analog_misc, 2'b00};
	localparam logic [9:0] addr_result_low     = {idx_result_low, 2'b00};
	localparam logic [9:0] addr_result_high    = {idx_result_high, 2'b00};
	localparam logic [9:0] addr_control_b      = {idx_control_b, 2'b00};
	localparam logic [9:0] addr_input_off_low  = {idx_input_off_low, 2'b00};
	localparam logic [9:0] addr_input_off_high = {idx_input_off_high, 2'b00};
	localparam logic [9:0] addr_converter_ctrl = {idx_converter_ctrl, 2'b00};
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] mask_control_b      = 8'hF7;
	localparam logic [7:0] mask_input_off_high = 8'h70;
	localparam logic [7:0] mask_analog_misc    = 8'h07;
	localparam logic [7:0] mask_converter_ctrl = 8'hA8;
	localparam logic [7:0] reset_byte          = 8'h00;
	// field positions
	localparam int pos_bipolar      = 7;
	localparam int pos_ext_ref      = 2;
	localparam int pos_int_ref_out  = 1;
	localparam int pos_cur_src      = 0;
	localparam int pos_conv_enable  = 7;
	localparam int pos_left_adjust  = 5;
	localparam int pos_done_flag    = 4;
	localparam int pos_auto_trigger = 3;
	localparam int pos_busy         = 2;
	// trigger sources
	typedef enum logic [2:0] {
		trig_free_running  = 3'b000,
		trig_comparator    = 3'b001,
		trig_ext_int0      = 3'b010,
		trig_t1_compare_a  = 3'b011,
		trig_t1_overflow   = 3'b100,
		trig_t1_compare_b  = 3'b101,
		trig_t1_capture    = 3'b110,
		trig_watchdog      = 3'b111
	} trigger_source_sel_type;
	// answer from the analog core
	typedef struct packed {
		logic       done;
		logic [9:0] value;
	} core_result_type;
endpackage

/* hw/result_formatter.sv */
// result formatter: maps a 10-bit result onto the two data bytes
// assumes the stored result is already coded (unipolar or two's complement)
`timescale 1ns/1ns
module result_formatter
	import adc_ctrl_pkg::*;
(
	input  wire logic [9:0] result_in,      // stored conversion result
	input  wire logic       left_adjust_in, // left alignment select
	output logic      [7:0] low_byte_out,   // low data byte view
	output logic      [7:0] high_byte_out   // high data byte view
);
	// alignment is combinational so a change shows at once
	always_comb begin
		if (left_adjust_in) begin
			high_byte_out = result_in[9:2];
			low_byte_out  = {result_in[1:0], 6'h00};
		end else begin
			high_byte_out = {6'h00, result_in[9:8]};
			low_byte_out  = result_in[7:0];
		end
	end
endmodule

/* hw/adc_result_trigger_ctrl.sv */
// converter result, trigger selection and pin input control with an APB slave
// assumes a 100 MHz clock, synchronous low reset, trigger flags as async inputs
//
// Notes on behaviour
// - a finished conversion loads its 10-bit result into the two data bytes
// - reading the low byte blocks result updates until the high byte is read
// - right alignment puts bits 9:8 in high byte 1:0, rest zero
// - left alignment puts bits 9:2 in high byte, 1:0 in low 7:6
// - bipolar select clear means unipolar; negative difference saturates
// - bipolar codes two's complement nine bits plus sign; unipolar plain ten
// - trigger source field acts only while auto trigger is enabled
// - a rising edge of the selected flag starts a conversion, source switch too
// - selecting free running never makes a trigger event itself
// - trigger field decodes to eight listed sources
// - low input-off bits disable pins 7:0 and force their port reads zero
// - high input-off bits 6:4 disable pins 10, 9 and 8
// - misc bit 2 selects the external reference pin
// - misc bit 1 drives the internal reference out on the output pin
// - left adjust change alters the data byte view immediately
// - done flag sets on update; writing one clears it
`timescale 1ns/1ns
module adc_result_trigger_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk_in,               // system clock
	input  wire logic        rst_b_in,             // synchronous reset, active low
	input  wire logic        psel_in,              // apb select
	input  wire logic        penable_in,           // apb enable
	input  wire logic        pwrite_in,            // apb direction
	input  wire logic [11:0] paddr_in,             // apb byte address
	input  wire logic [31:0] pwdata_in,            // apb write data
	output logic      [31:0] prdata_out,           // apb read data
	output logic             pready_out,           // apb ready
	output logic             pslverr_out,          // apb error
	input  wire logic        core_done_in,         // core finished, one-cycle pulse
	input  wire logic [9:0]  core_value_in,        // raw core code
	input  wire logic        core_negative_in,     // input difference negative
	input  wire logic [7:0]  trigger_flags_in,     // source flags, async
	input  wire logic [10:0] pin_digital_in,       // raw pin levels, async
	output logic             conversion_start_out, // start pulse to core
	output logic             bipolar_select_out,   // bipolar mode to core
	output logic [10:0]      pin_buffer_off_out,   // input buffer disables
	output logic [10:0]      port_input_out,       // pin reads after disable
	output logic             ext_reference_in_enable_out,  // take external ref
	output logic             int_reference_out_enable_out, // drive internal ref out
	output logic             current_source_enable_out     // current source on
);
	localparam logic [9:0] full_scale = 10'h3FF;

	typedef struct packed {
		logic [7:0]  control_b;
		logic [7:0]  input_off_low;
		logic [7:0]  input_off_high;
		logic [7:0]  analog_misc;
		logic [7:0]  converter_ctrl;
		logic        done_flag;
		logic [9:0]  result;
		logic        locked;
		logic [7:0]  flag_meta;
		logic [7:0]  flag_sync;
		logic        trig_prev;
		logic [10:0] pin_meta;
		logic [10:0] pin_sync;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
		logic        start;
		logic        busy;
		logic [10:0] port_in;
	} state_type;

	state_type state_r;
	state_type state_nxt;

	logic [7:0] low_view;
	logic [7:0] high_view;

	// decodes an aligned byte address to a mapped register
	function automatic logic is_mapped(input logic [9:0] a);
		return (a == addr_analog_misc) || (a == addr_result_low) ||
			(a == addr_result_high) || (a == addr_control_b) ||
			(a == addr_input_off_low) || (a == addr_input_off_high) ||
			(a == addr_converter_ctrl);
	endfunction

	// codes a raw core value in the current mode
	function automatic logic [9:0] code_result(input logic [9:0] raw, input logic neg,
		input logic bip);
		if (bip)
			return raw;
		else if (neg)
			return full_scale;
		else
			return raw;
	endfunction

	result_formatter u_formatter (
		.result_in      (state_r.result),
		.left_adjust_in (state_r.converter_ctrl[pos_left_adjust]),
		.low_byte_out   (low_view),
		.high_byte_out  (high_view)
	);

	always_comb begin
		logic        access;
		logic        wr;
		logic        rd;
		logic [9:0]  waddr;
		logic [7:0]  wbyte;
		logic        sel_flag;
		logic        trig_edge;
		logic        clear_done;
		logic        conv_en;
		logic        auto_en;
		logic [10:0] off_bits;
		access     = 1'b0;
		wr         = 1'b0;
		rd         = 1'b0;
		waddr      = 10'h000;
		wbyte      = 8'h00;
		sel_flag   = 1'b0;
		trig_edge  = 1'b0;
		clear_done = 1'b0;
		conv_en    = 1'b0;
		auto_en    = 1'b0;
		off_bits   = 11'h000;
		state_nxt  = state_r;

		// two-stage synchronisers for flags and pins
		state_nxt.flag_meta = trigger_flags_in;
		state_nxt.flag_sync = state_r.flag_meta;
		state_nxt.pin_meta  = pin_digital_in;
		state_nxt.pin_sync  = state_r.pin_meta;

		// apb: answer registered in the cycle after the first access cycle, ready for one cycle
		access = psel_in && penable_in && !state_r.ready;
		// aligned byte address; addresses above the map fold onto unmapped zero
		waddr  = (paddr_in[11:10] == 2'b00) ? {paddr_in[9:2], 2'b00} : 10'h000;
		wbyte  = pwdata_in[7:0];
		wr     = access && pwrite_in && is_mapped(waddr);
		rd     = access && !pwrite_in && is_mapped(waddr);
		state_nxt.ready  = access;
		state_nxt.slverr = access && !is_mapped(waddr);
		state_nxt.rdata  = 32'h0000_0000;
		if (rd) begin
			case (waddr)
				addr_analog_misc:    state_nxt.rdata[7:0] = state_r.analog_misc;
				addr_result_low:     state_nxt.rdata[7:0] = low_view;
				addr_result_high:    state_nxt.rdata[7:0] = high_view;
				addr_control_b:      state_nxt.rdata[7:0] = state_r.control_b;
				addr_input_off_low:  state_nxt.rdata[7:0] = state_r.input_off_low;
				addr_input_off_high: state_nxt.rdata[7:0] = state_r.input_off_high;
				addr_converter_ctrl: state_nxt.rdata[7:0] = state_r.converter_ctrl |
					{3'b000, state_r.done_flag, 1'b0, state_r.busy, 2'b00};
				default:             state_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// lock on low byte read, release on high byte read
		if (rd && waddr == addr_result_low)
			state_nxt.locked = 1'b1;
		else if (rd && waddr == addr_result_high)
			state_nxt.locked = 1'b0;

		// register writes, reserved bits masked to zero
		if (wr) begin
			case (waddr)
				addr_analog_misc:    state_nxt.analog_misc = wbyte & mask_analog_misc;
				addr_control_b:      state_nxt.control_b = wbyte & mask_control_b;
				addr_input_off_low:  state_nxt.input_off_low = wbyte;
				addr_input_off_high: state_nxt.input_off_high =
					wbyte & mask_input_off_high;
				addr_converter_ctrl: begin
					state_nxt.converter_ctrl = wbyte & mask_converter_ctrl;
					clear_done = wbyte[pos_done_flag];
				end
				default:             state_nxt.analog_misc = state_r.analog_misc;
			endcase
		end

		// selected source flag; free running has no flag of its own
		case (trigger_source_sel_type'(state_r.control_b[2:0]))
			trig_free_running: sel_flag = 1'b0;
			trig_comparator:   sel_flag = state_r.flag_sync[1];
			trig_ext_int0:     sel_flag = state_r.flag_sync[2];
			trig_t1_compare_a: sel_flag = state_r.flag_sync[3];
			trig_t1_overflow:  sel_flag = state_r.flag_sync[4];
			trig_t1_compare_b: sel_flag = state_r.flag_sync[5];
			trig_t1_capture:   sel_flag = state_r.flag_sync[6];
			trig_watchdog:     sel_flag = state_r.flag_sync[7];
			default:           sel_flag = 1'b0;
		endcase
		// edge seen on the muxed signal, so a source switch counts too
		state_nxt.trig_prev = sel_flag;
		trig_edge = sel_flag && !state_r.trig_prev;
		conv_en   = state_r.converter_ctrl[pos_conv_enable];
		auto_en   = state_r.converter_ctrl[pos_auto_trigger];
		state_nxt.start = conv_en && auto_en && trig_edge;
		if (state_nxt.start)
			state_nxt.busy = 1'b1;

		// result update unless a low byte read left it locked
		if (core_done_in) begin
			state_nxt.busy = 1'b0;
			if (!state_r.locked) begin
				state_nxt.result = code_result(core_value_in, core_negative_in,
					state_r.control_b[pos_bipolar]);
			end
		end
		// done flag: set wins over a write-one clear
		if (core_done_in && !state_r.locked)
			state_nxt.done_flag = 1'b1;
		else if (clear_done)
			state_nxt.done_flag = 1'b0;
		if (!conv_en)
			state_nxt.busy = 1'b0;

		// pin input disables and forced-zero port reads
		off_bits = {state_r.input_off_high[6:4], state_r.input_off_low};
		state_nxt.port_in = state_r.pin_sync & ~off_bits;
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from flip-flops
	assign prdata_out                   = state_r.rdata;
	assign pready_out                   = state_r.ready;
	assign pslverr_out                  = state_r.slverr;
	assign conversion_start_out         = state_r.start;
	assign bipolar_select_out           = state_r.control_b[pos_bipolar];
	assign pin_buffer_off_out           = {state_r.input_off_high[6:4], state_r.input_off_low};
	assign port_input_out               = state_r.port_in;
	assign ext_reference_in_enable_out  = state_r.analog_misc[pos_ext_ref];
	assign int_reference_out_enable_out = state_r.analog_misc[pos_int_ref_out];
	assign current_source_enable_out    = state_r.analog_misc[pos_cur_src];
endmodule

/* bench/adc_ctrl_asserts.sv */
// checker: register controls, reserved bits, pin gating, start pulse
// assumes a bind onto the top module, one clock, synchronous low reset
`timescale 1ns/1ns
module adc_ctrl_asserts
	import adc_ctrl_pkg::*;
(
	input wire logic        clk_in, rst_b_in, psel_in, penable_in, pwrite_in, // bus
	input wire logic        pready_out, conversion_start_out, bipolar_select_out, // answers
	input wire logic        ext_reference_in_enable_out, int_reference_out_enable_out, // refs
	input wire logic        current_source_enable_out, // current source
	input wire logic [11:0] paddr_in, // address
	input wire logic [31:0] pwdata_in, prdata_out, // data
	input wire logic [10:0] pin_buffer_off_out, port_input_out // pins
);
	logic [9:0] a;
	logic [7:0] rsv;
	logic       wt;
	logic       ra;
	// taken write, answered read, reserved bits of the register read
	assign a   = paddr_in[11:10] == 2'b00 ? paddr_in[9:0] : 10'h000;
	assign wt  = psel_in && penable_in && pwrite_in && !pready_out;
	assign ra  = pready_out && !pwrite_in;
	assign rsv = a == addr_input_off_high ? 8'h8F : a == addr_analog_misc ? 8'hF8 : 8'h00;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	low_off_write_a: assert property (wt && a == addr_input_off_low |=>
		pin_buffer_off_out[7:0] == $past(pwdata_in[7:0])) else $error("low disables wrong");
	high_off_write_a: assert property (wt && a == addr_input_off_high |=>
		pin_buffer_off_out[10:8] == $past(pwdata_in[6:4])) else $error("high disables wrong");
	misc_write_a: assert property (wt && a == addr_analog_misc |=>
		{ext_reference_in_enable_out, int_reference_out_enable_out, current_source_enable_out}
		== $past(pwdata_in[2:0])) else $error("misc controls wrong");
	bipolar_write_a: assert property (wt && a == addr_control_b |=>
		bipolar_select_out == $past(pwdata_in[7])) else $error("bipolar select wrong");
	ctlb_reserved_a: assert property (ra && a == addr_control_b |-> !prdata_out[3])
		else $error("reserved control bit set");
	reserved_zero_a: assert property (ra |-> (prdata_out & {24'hFFFFFF, rsv}) == 32'h0)
		else $error("reserved bits set");
	pin_gate_a: assert property ((port_input_out & pin_buffer_off_out
		& $past(pin_buffer_off_out)) == 11'h000) else $error("disabled pin reads one");
	start_pulse_a: assert property (conversion_start_out |=> !conversion_start_out)
		else $error("start pulse too long");
	cover property (conversion_start_out);
	cover property (ra && a == addr_result_high);
	cover property (wt && a == addr_converter_ctrl);
endmodule

bind adc_result_trigger_ctrl adc_ctrl_asserts chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
	.conversion_start_out(conversion_start_out), .bipolar_select_out(bipolar_select_out),
	.ext_reference_in_enable_out(ext_reference_in_enable_out),
	.int_reference_out_enable_out(int_reference_out_enable_out),
	.current_source_enable_out(current_source_enable_out), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pin_buffer_off_out(pin_buffer_off_out),
	.port_input_out(port_input_out));

/* bench/core_model.sv */
// core model: answers each start with a done pulse delay_in plus one cycles later
// assumes the bench sets code and sign before the start
`timescale 1ns/1ns
module core_model (
	input  wire logic       clk_in, rst_b_in, start_in, // clock, reset, start
	input  wire logic [9:0] code_in,   // code to return
	input  wire logic       neg_in,    // negative difference
	input  wire logic [3:0] delay_in,  // answer delay
	output logic            done_out,  // done pulse
	output logic      [9:0] value_out, // valid with done only
	output logic            negative_out // valid with done only
);
	logic [3:0] count_r;
	logic       busy_r;
	// outside done the result lines toggle so stale values match only every other cycle
	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		value_out <= ~value_out;
		negative_out <= ~negative_out;
		if (!rst_b_in) begin
			busy_r <= 1'b0;
			value_out <= 10'h155;
		end else if (start_in) begin
			busy_r <= 1'b1;
			count_r <= delay_in;
		end else if (busy_r && count_r == 4'h0) begin
			busy_r <= 1'b0;
			done_out <= 1'b1;
			value_out <= code_in;
			negative_out <= neg_in;
		end else begin
			count_r <= count_r - 4'h1;
		end
	end
endmodule

/* bench/adc_result_trigger_ctrl_test.sv */
// bench: registers, pin gating, trigger sources, result layout, locking
// assumes the core model and the bound checker beside the block
`timescale 1ns/1ns
module adc_result_trigger_ctrl_test
	import adc_ctrl_pkg::*;
;
	logic        clk_in, rst_b_in, psel, penable, pwrite, pready, perr, err, start, done;
	logic        neg, mneg, bip;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [9:0]  code, mcode;
	logic [7:0]  flags;
	logic [10:0] pins, boff, port;
	logic [2:0]  refs;
	int          num_errors, total_checks, starts, base, cycles;
	adc_result_trigger_ctrl dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .core_done_in(done),
		.core_value_in(mcode), .core_negative_in(mneg), .trigger_flags_in(flags),
		.pin_digital_in(pins), .conversion_start_out(start), .bipolar_select_out(bip),
		.pin_buffer_off_out(boff), .port_input_out(port),
		.ext_reference_in_enable_out(refs[2]), .int_reference_out_enable_out(refs[1]),
		.current_source_enable_out(refs[0]));
	core_model core_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start), .code_in(code),
		.neg_in(neg), .delay_in(code[3:0]), .done_out(done), .value_out(mcode),
		.negative_out(mneg));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// start pulses counted off the sampling edge; hang guard
	always @(negedge clk_in) begin
		starts += int'(start === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one transfer; the request stands until ready is seen at an edge
	task automatic ap(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, a};
		pwdata <= {24'h000000, d};
		@(posedge clk_in);
		penable <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		q = prdata;
		err = perr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
		ap(1'b0, a, 8'h00);
		chk(n, q, {24'h000000, e});
	endtask
	task automatic ws(input int n, input int e, input string m);
		repeat (n) @(posedge clk_in);
		chk(m, starts - base, e);
		base = starts;
	endtask
	// other flags rise first, then the selected one
	task automatic conv(input logic [2:0] s, input logic [9:0] c, input logic n);
		code <= c;
		neg <= n;
		base = starts;
		flags <= ~(8'h01 << s);
		ws(8, 0, "other flags");
		flags <= 8'hFF;
		ws(30, 1, "selected flag");
		flags <= 8'h00;
	endtask
	task automatic t_regs();
		logic [9:0] al [6] = '{addr_analog_misc, addr_result_low, addr_result_high,
			addr_control_b, addr_input_off_low, addr_input_off_high};
		logic [7:0] ex [6] = '{8'h07, 8'h00, 8'h00, 8'hF7, 8'hFF, 8'h70};
		foreach (al[i]) rd(al[i], 8'h00, "reset value");
		foreach (al[i]) ap(1'b1, al[i], 8'hFF);
		foreach (al[i]) rd(al[i], ex[i], "written value");
		chk("disables", boff, 11'h7FF);
		chk("references", refs, 3'h7);
		chk("bipolar", bip, 1'b1);
		pins <= 11'h7FF;
		ap(1'b1, addr_input_off_low, 8'h5A);
		ap(1'b1, addr_input_off_high, 8'h50);
		repeat (5) @(posedge clk_in);
		chk("port reads", port, 11'h2A5);
		rd(10'h000, 8'h00, "unmapped read");
		chk("unmapped error", err, 1'b1);
	endtask
	task automatic t_sources();
		int v;
		ap(1'b1, addr_converter_ctrl, 8'h88);
		for (int s = 1; s < 8; s++) begin
			v = s * 73 + 512;
			ap(1'b1, addr_control_b, 8'(s));
			conv(3'(s), 10'(v), 1'b0);
			rd(addr_converter_ctrl, 8'h98, "done set");
			ap(1'b1, addr_converter_ctrl, 8'h98);
			rd(addr_converter_ctrl, 8'h88, "done clear");
			rd(addr_result_low, 8'(v), "right low");
			rd(addr_result_high, 8'(v >> 8), "right high");
		end
		ap(1'b1, addr_converter_ctrl, 8'hA8);
		rd(addr_result_low, 8'hC0, "left low");
		rd(addr_result_high, 8'hFF, "left high");
		ap(1'b1, addr_converter_ctrl, 8'h88);
	endtask
	task automatic t_lock();
		ap(1'b1, addr_control_b, 8'h01);
		conv(3'h1, 10'h123, 1'b0);
		rd(addr_result_low, 8'h23, "low");
		conv(3'h1, 10'h2BC, 1'b0);
		rd(addr_result_high, 8'h01, "locked high");
		rd(addr_result_low, 8'h23, "dropped low");
		rd(addr_result_high, 8'h01, "dropped high");
		conv(3'h1, 10'h2BC, 1'b1);
		rd(addr_result_high, 8'h03, "saturated");
		ap(1'b1, addr_control_b, 8'h81);
		conv(3'h1, 10'h2C5, 1'b1);
		rd(addr_result_low, 8'hC5, "bipolar low");
		rd(addr_result_high, 8'h02, "bipolar high");
	endtask
	task automatic t_switch();
		base = starts;
		ap(1'b1, addr_control_b, 8'h02);
		flags <= 8'h02;
		ws(8, 0, "unselected flag");
		ap(1'b1, addr_control_b, 8'h01);
		ws(30, 1, "switch to set source");
		ap(1'b1, addr_control_b, 8'h00);
		ws(30, 0, "free running");
		ap(1'b1, addr_converter_ctrl, 8'h80);
		ap(1'b1, addr_control_b, 8'h01);
		flags <= 8'h00;
		ws(8, 0, "flag fall");
		flags <= 8'h02;
		ws(30, 0, "auto off");
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{rst_b_in, psel, penable, pwrite, neg} = '0;
		{paddr, pwdata, code, flags, pins} = '0;
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_regs();
		t_sources();
		t_lock();
		t_switch();
		report_and_stop();
	end
endmodule
